// >>> hw/backlight_pkg.sv
package backlight_pkg;

  // Register offsets, as seen on the byte-wide register port
  localparam logic [7:0] INT_STAT_ADDR     = 8'h02;
  localparam logic [7:0] INT_ENABLE_ADDR   = 8'h03;
  localparam logic [7:0] BL_CONFIG_ADDR    = 8'h04;
  localparam logic [7:0] LED_GROUP_ADDR    = 8'h05;
  localparam logic [7:0] PWM_SCALE_ADDR    = 8'h06;
  localparam logic [7:0] OFF_TIMEOUT_ADDR  = 8'h07;
  localparam logic [7:0] DIM_TIMEOUT_ADDR  = 8'h08;

  // Flag and enable bit positions
  localparam int SENSOR_A_BIT  = 0;
  localparam int SENSOR_B_BIT  = 1;
  localparam int OVERVOLT_BIT  = 2;
  localparam int THERMAL_BIT   = 3;
  localparam int SHORT_BIT     = 4;
  localparam int FADE_DONE_BIT = 5;

  // Configuration field positions
  localparam int SOURCE_SEL_BIT  = 7;
  localparam int SENSOR_B_EN_BIT = 6;
  localparam int LEVEL_MSB       = 5;
  localparam int LEVEL_LSB       = 3;
  localparam int LAW_MSB         = 2;
  localparam int LAW_LSB         = 1;
  localparam int OVERRIDE_BIT    = 0;

  // Write masks; reserved bits never store
  localparam logic [7:0] IRQ_MASK   = 8'h3F;
  localparam logic [7:0] LED7_MASK  = 8'h7F;
  localparam logic [7:0] CFG_MASK   = 8'hFF;

  // Reset value and first level code that forces zero current
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [2:0] LEVEL_OFF_FIRST = 3'h5;

  // Timing
  localparam int CLOCK_HZ       = 10_000_000;
  localparam int SECOND_CYCLES  = CLOCK_HZ;
  localparam int GAP_TIME_US    = 50;
  localparam int GAP_CYCLES     = GAP_TIME_US * (CLOCK_HZ / 1_000_000);

  // Register access request from the serial-bus front end
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Raw hardware event pulses
  typedef struct packed {
    logic fadeDone;
    logic shortFault;
    logic thermalFault;
    logic overvoltage;
    logic sensorBTrip;
    logic sensorATrip;
  } event_type;

  // Timeout sequencer states
  typedef enum logic [3:0] {
    TO_IDLE = 4'b0001,
    TO_DIM  = 4'b0010,
    TO_OFF  = 4'b0100,
    TO_DONE = 4'b1000
  } timeout_state_type;

endpackage : backlight_pkg

// >>> hw/backlight_ctrl_irq_regs.sv
`timescale 1ns/1ps
// Functional notes
// - fade-out finish flag gates interrupt by bit5
// - short flag always set, irq by bit4
// - thermal flag always set, irq by bit3
// - overvoltage flag always set, irq by bit2
// - sensor B trip flag, irq by bit1
// - sensor A trip flag, irq by bit0
// - config bit7 picks controlling light sensor
// - config bit6 enables sensor B, drops LED6
// - level codes 101-111 force zero current
// - level field reports use, auto overwrites
// - two-bit transfer law selects time profile
// - config bit0 enables fade override
// - per-LED bit makes sink independent
// - per-LED bit lets PWM scale current
// - off timeout in seconds, zero disables
// - off count starts after dim expiry
// - dim expiry switches to dim current
// - dim count starts at maximum current
// - flags clear on write one only
// - interrupt config gives 50 us gap
// - auto control follows comparator level

module backlight_ctrl_irq_regs #(
  parameter int SECOND_COUNT = backlight_pkg::SECOND_CYCLES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire backlight_pkg::reg_req_type regReq,
  output logic [7:0]                     regRdata,
  input  wire backlight_pkg::event_type  hwEvents,
  input  wire logic                      intConfig,
  input  wire logic                      autoSensorControl,
  input  wire logic [2:0]                autoLevel,
  input  wire logic                      backlightOn,
  input  wire logic                      atMaxCurrent,
  input  wire logic                      sensorAInput,
  input  wire logic                      sensorBInput,
  input  wire logic                      pwmIn,
  output logic                           hostIrq,
  output logic                           sensorSelected,
  output logic                           sensorBEnable,
  output logic                           ledSink6Enable,
  output logic [2:0]                     brightnessLevel,
  output logic                           zeroCurrent,
  output logic [1:0]                     transferLaw,
  output logic                           cubicSteps,
  output logic                           fadeOverride,
  output logic [6:0]                     ledOn,
  output logic [6:0]                     ledPwmGate,
  output logic                           dimRequest,
  output logic                           offRequest
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [5:0] flags_r;
  logic [5:0] irqEnable_r;
  logic [7:0] config_r;
  logic [6:0] ledSelect_r;
  logic [6:0] pwmEnable_r;
  logic [6:0] offTimeout_r;
  logic [6:0] dimTimeout_r;
  logic [5:0] eventVec;
  logic       wrStat;
  logic [1:0] pinA_r;
  logic [1:0] pinB_r;
  logic [1:0] pinPwm_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = regReq.write && (a == off);
  endfunction : hit

  assign eventVec = {hwEvents.fadeDone, hwEvents.shortFault, hwEvents.thermalFault,
                     hwEvents.overvoltage, hwEvents.sensorBTrip, hwEvents.sensorATrip};
  assign wrStat   = hit(regReq.addr, backlight_pkg::INT_STAT_ADDR);

  // Pin inputs through two flops before use
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinA_r   <= 2'h0;
      pinB_r   <= 2'h0;
      pinPwm_r <= 2'h0;
    end else begin
      pinA_r   <= {pinA_r[0], sensorAInput};
      pinB_r   <= {pinB_r[0], sensorBInput};
      pinPwm_r <= {pinPwm_r[0], pwmIn};
    end
  end

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_r <= 6'h00;
    end else begin
      flags_r <= (flags_r & ~(wrStat ? regReq.wdata[5:0] : 6'h00))
                 | eventVec;
    end
  end

  // Writable control registers, reserved bits masked off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqEnable_r  <= 6'h00;
      ledSelect_r  <= 7'h00;
      pwmEnable_r  <= 7'h00;
      offTimeout_r <= 7'h00;
      dimTimeout_r <= 7'h00;
    end else begin
      if (hit(regReq.addr, backlight_pkg::INT_ENABLE_ADDR)) begin
        irqEnable_r <= regReq.wdata[5:0] & backlight_pkg::IRQ_MASK[5:0];
      end
      if (hit(regReq.addr, backlight_pkg::LED_GROUP_ADDR)) begin
        ledSelect_r <= regReq.wdata[6:0];
      end
      if (hit(regReq.addr, backlight_pkg::PWM_SCALE_ADDR)) begin
        pwmEnable_r <= regReq.wdata[6:0];
      end
      if (hit(regReq.addr, backlight_pkg::OFF_TIMEOUT_ADDR)) begin
        offTimeout_r <= regReq.wdata[6:0];
      end
      if (hit(regReq.addr, backlight_pkg::DIM_TIMEOUT_ADDR)) begin
        dimTimeout_r <= regReq.wdata[6:0];
      end
    end
  end

  // Configuration; level follows sensors in auto mode, even over a write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      config_r <= backlight_pkg::REG_RESET;
    end else begin
      if (hit(regReq.addr, backlight_pkg::BL_CONFIG_ADDR)) begin
        config_r <= regReq.wdata & backlight_pkg::CFG_MASK;
      end
      if (autoSensorControl) begin
        config_r[backlight_pkg::LEVEL_MSB:backlight_pkg::LEVEL_LSB] <= autoLevel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt line with optional release gap

  logic        pending;
  logic        pendingPrev_r;
  logic [15:0] gapCnt_r;

  assign pending = |(flags_r & irqEnable_r);

  // Gap starts when the host clears while events remain
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gapCnt_r      <= 16'h0000;
      pendingPrev_r <= 1'b0;
    end else begin
      pendingPrev_r <= pending;
      if (intConfig && wrStat && pending && (|(regReq.wdata[5:0] & flags_r))) begin
        gapCnt_r <= 16'(backlight_pkg::GAP_CYCLES);
      end else if (gapCnt_r != 16'h0000) begin
        gapCnt_r <= gapCnt_r - 16'h0001;
      end
    end
  end

  // Line held low during the gap; otherwise follows pending
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hostIrq <= 1'b0;
    end else begin
      hostIrq <= pending && (gapCnt_r <= 16'h0001) && !(intConfig && wrStat && pending);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dim and off timeouts, one-second tick

  // Phase, prescaler and whole-second count
  backlight_pkg::timeout_state_type state_r;
  logic [31:0]                      tick_r;
  logic [6:0]                       secs_r;
  logic                             tickPulse;

  // Wrap at one second; restart per phase so each wait is whole seconds
  assign tickPulse = (tick_r == 32'(SECOND_COUNT - 1));

  // Second prescaler, held at zero while the backlight is off or the sequencer is in TO_IDLE
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !backlightOn || state_r == backlight_pkg::TO_IDLE) begin
      tick_r <= 32'h0000_0000;
    end else begin
      tick_r <= tickPulse ? 32'h0000_0000 : tick_r + 32'h0000_0001;
    end
  end

  // Sequencer: max current -> dim wait -> off wait -> done
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !backlightOn) begin
      state_r    <= backlight_pkg::TO_IDLE;
      secs_r     <= 7'h00;
      dimRequest <= 1'b0;
      offRequest <= 1'b0;
    end else begin
      case (state_r)
        backlight_pkg::TO_IDLE: begin
          secs_r <= 7'h00;
          if (atMaxCurrent) begin
            state_r <= (dimTimeout_r != 7'h00) ? backlight_pkg::TO_DIM : backlight_pkg::TO_OFF;
          end
        end
        backlight_pkg::TO_DIM: begin
          if (dimTimeout_r == 7'h00) begin
            state_r <= backlight_pkg::TO_OFF;
          end else if (tickPulse) begin
            if (secs_r + 7'h01 >= dimTimeout_r) begin
              dimRequest <= 1'b1;
              secs_r     <= 7'h00;
              state_r    <= backlight_pkg::TO_OFF;
            end else begin
              secs_r <= secs_r + 7'h01;
            end
          end
        end
        backlight_pkg::TO_OFF: begin
          if (offTimeout_r != 7'h00 && tickPulse) begin
            if (secs_r + 7'h01 >= offTimeout_r) begin
              offRequest <= 1'b1;
              state_r    <= backlight_pkg::TO_DONE;
            end else begin
              secs_r <= secs_r + 7'h01;
            end
          end
        end
        default: begin
          state_r <= backlight_pkg::TO_DONE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control outputs

  logic levelOff;

  assign levelOff = config_r[backlight_pkg::LEVEL_MSB:backlight_pkg::LEVEL_LSB]
                    >= backlight_pkg::LEVEL_OFF_FIRST;

  // Registered outputs, updated every cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sensorSelected  <= 1'b0;
      sensorBEnable   <= 1'b0;
      ledSink6Enable  <= 1'b1;
      brightnessLevel <= 3'h0;
      zeroCurrent     <= 1'b0;
      transferLaw     <= 2'h0;
      cubicSteps      <= 1'b0;
      fadeOverride    <= 1'b0;
      ledOn           <= 7'h00;
      ledPwmGate      <= 7'h7F;
    end else begin
      sensorSelected  <= config_r[backlight_pkg::SOURCE_SEL_BIT] ? pinB_r[1] : pinA_r[1];
      sensorBEnable   <= config_r[backlight_pkg::SENSOR_B_EN_BIT];
      ledSink6Enable  <= !config_r[backlight_pkg::SENSOR_B_EN_BIT];
      brightnessLevel <= config_r[backlight_pkg::LEVEL_MSB:backlight_pkg::LEVEL_LSB];
      zeroCurrent     <= levelOff;
      transferLaw     <= config_r[backlight_pkg::LAW_MSB:backlight_pkg::LAW_LSB];
      cubicSteps      <= config_r[backlight_pkg::LAW_MSB];
      fadeOverride    <= config_r[backlight_pkg::OVERRIDE_BIT];
      // Backlight sinks follow the shared enable; independents stay as selected
      ledOn           <= ledSelect_r | {7{backlightOn & !offRequest}};
      ledPwmGate      <= ~pwmEnable_r | {7{pinPwm_r[1]}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets and reserved bits read zero

  always_comb begin
    regRdata = 8'h00;
    if (regReq.addr == backlight_pkg::INT_STAT_ADDR) begin
      regRdata = {2'b00, flags_r};
    end else if (regReq.addr == backlight_pkg::INT_ENABLE_ADDR) begin
      regRdata = {2'b00, irqEnable_r};
    end else if (regReq.addr == backlight_pkg::BL_CONFIG_ADDR) begin
      regRdata = config_r;
    end else if (regReq.addr == backlight_pkg::LED_GROUP_ADDR) begin
      regRdata = {1'b0, ledSelect_r};
    end else if (regReq.addr == backlight_pkg::PWM_SCALE_ADDR) begin
      regRdata = {1'b0, pwmEnable_r};
    end else if (regReq.addr == backlight_pkg::OFF_TIMEOUT_ADDR) begin
      regRdata = {1'b0, offTimeout_r};
    end else if (regReq.addr == backlight_pkg::DIM_TIMEOUT_ADDR) begin
      regRdata = {1'b0, dimTimeout_r};
    end
  end

endmodule : backlight_ctrl_irq_regs

// >>> bench/backlight_monitor.sv
`timescale 1ns/1ps
module backlight_monitor #(
  parameter int SECOND_COUNT = 20
) (
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire backlight_pkg::reg_req_type regReq,
  input wire backlight_pkg::event_type   hwEvents,
  input wire logic                       intConfig,
  input wire logic                       backlightOn,
  input wire logic                       atMaxCurrent,
  input wire logic                       pwmIn,
  input wire logic                       hostIrq,
  input wire logic                       sensorBEnable,
  input wire logic                       ledSink6Enable,
  input wire logic [6:0]                 ledOn,
  input wire logic [6:0]                 ledPwmGate,
  input wire logic                       dimRequest,
  input wire logic                       offRequest
);
  default clocking mcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int maxRun_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Time lit at full current; no timer may expire sooner
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !backlightOn || !atMaxCurrent) begin
      maxRun_r <= 0;
    end else begin
      maxRun_r <= maxRun_r + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_sink6_swap: assert property (
    ledSink6Enable == !sensorBEnable) else $error("sink 6 not opposite sensor B");
  a_led_follow: assert property (
    $past(rst_n) && $past(backlightOn) && !$past(offRequest) |-> ledOn == 7'h7F)
    else $error("shared sinks not lit");
  a_pwm_pass: assert property (
    pwmIn [*4] |=> ledPwmGate == 7'h7F) else $error("high PWM still gates");
  // Writes are the only way to lower the line once raised
  a_irq_sticky: assert property (
    hostIrq && !regReq.write && !$past(regReq.write) && !$past(regReq.write, 2)
    |=> hostIrq) else $error("interrupt dropped without a write");
  a_irq_cause: assert property (
    $rose(hostIrq) && !intConfig |-> $past(hwEvents) != '0 || $past(hwEvents, 2) != '0
    || $past(regReq.write) || $past(regReq.write, 2)) else $error("interrupt without cause");
  a_req_release: assert property (
    !backlightOn |=> !dimRequest && !offRequest) else $error("timeout request held");
  a_dim_early: assert property (
    $rose(dimRequest) |-> maxRun_r >= SECOND_COUNT) else $error("dim before a second");
  a_off_early: assert property (
    $rose(offRequest) |-> maxRun_r >= SECOND_COUNT) else $error("off before a second");
  c_irq: cover property ($rose(hostIrq));
  c_dim: cover property ($rose(dimRequest));
  c_off: cover property ($rose(offRequest));
endmodule : backlight_monitor

bind backlight_ctrl_irq_regs backlight_monitor #(.SECOND_COUNT(SECOND_COUNT)) mon_u (
  .ref_clk, .rst_n, .regReq, .hwEvents, .intConfig, .backlightOn, .atMaxCurrent, .pwmIn,
  .hostIrq, .sensorBEnable, .ledSink6Enable, .ledOn, .ledPwmGate, .dimRequest, .offRequest);

// >>> bench/backlight_host.sv
`timescale 1ns/1ps
module backlight_host (
  input  wire logic                  ref_clk,
  output backlight_pkg::reg_req_type regReq,
  input  wire logic [7:0]            regRdata
);
  initial regReq = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle strobe; idle cycle after so two writes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk);
    regReq <= '0;
  endtask : wr
  // Flags drop only where a one is written
  task automatic clr(input logic [7:0] m);
    wr(backlight_pkg::INT_STAT_ADDR, m);
  endtask : clr
  // Read data is combinational, taken at the edge that ends the access
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    v = regRdata;
    regReq <= '0;
  endtask : rd
endmodule : backlight_host

// >>> bench/backlight_ctrl_irq_regs_test.sv
`timescale 1ns/1ps
module backlight_ctrl_irq_regs_test;
  localparam int SC = 20;
  logic ref_clk, rst_n, intConfig, autoSensorControl, backlightOn, atMaxCurrent, pwmIn;
  logic sensorAInput, sensorBInput, hostIrq, sensorSelected, sensorBEnable, ledSink6Enable;
  logic zeroCurrent, cubicSteps, fadeOverride, dimRequest, offRequest;
  logic [2:0] autoLevel, brightnessLevel;
  logic [1:0] transferLaw;
  logic [6:0] ledOn, ledPwmGate;
  logic [7:0] regRdata, d, v;
  backlight_pkg::reg_req_type regReq;
  backlight_pkg::event_type   hwEvents;
  int bad_count, n_checks, cycles, n;
  // Address, written byte, read-back byte
  logic [23:0] rows [7] = '{24'h03_FF3F, 24'h04_C3C3, 24'h05_FF7F, 24'h06_FF7F,
                            24'h07_FF7F, 24'h08_FF7F, 24'h09_5500};
  backlight_ctrl_irq_regs #(.SECOND_COUNT(SC)) dut_u (
    .ref_clk, .rst_n, .regReq, .regRdata, .hwEvents, .intConfig, .autoSensorControl,
    .autoLevel, .backlightOn, .atMaxCurrent, .sensorAInput, .sensorBInput, .pwmIn,
    .hostIrq, .sensorSelected, .sensorBEnable, .ledSink6Enable, .brightnessLevel,
    .zeroCurrent, .transferLaw, .cubicSteps, .fadeOverride, .ledOn, .ledPwmGate,
    .dimRequest, .offRequest);
  backlight_host host_u (.ref_clk, .regReq, .regRdata);
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard; the sequence needs about 3700 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Settle one step past the edge so outputs are read after they land
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic pulse(input logic [5:0] e);
    @(posedge ref_clk) hwEvents <= e;
    @(posedge ref_clk) hwEvents <= '0;
  endtask : pulse
  task automatic countTo(input logic off);
    n = 0;
    while ((off ? offRequest : dimRequest) !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
  endtask : countTo
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, intConfig, autoSensorControl, autoLevel, backlightOn, atMaxCurrent} = '0;
    {sensorBInput, pwmIn} = '0;
    sensorAInput = 1'b1;
    hwEvents = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      host_u.wr(rows[i][23:16], rows[i][15:8]);
      host_u.rd(rows[i][23:16], d);
      check(d, rows[i][7:0]);
    end
    $display("register map done");
    // All eight level codes; sensor A high, B low
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], i[2:0], i[1:0], i[0]};
      host_u.wr(8'h04, v);
      tick(3);
      check({1'b0, sensorSelected, sensorBEnable, ledSink6Enable, zeroCurrent, brightnessLevel},
            {1'b0, !i[1], i[0], !i[0], i >= 5, i[2:0]});
      check({4'h0, transferLaw, cubicSteps, fadeOverride},
            {4'h0, i[1:0], i[1], i[0]});
    end
    // Swap pin levels so each selection shows its own sensor
    @(posedge ref_clk) {sensorAInput, sensorBInput} <= 2'b01;
    host_u.wr(8'h04, 8'h80);
    tick(4);
    check(sensorSelected, 1'b1);
    host_u.wr(8'h04, 8'h00);
    tick(3);
    check(sensorSelected, 1'b0);
    // Sensor control overrides a forced level
    @(posedge ref_clk) autoSensorControl <= 1'b1;
    @(posedge ref_clk) autoLevel <= 3'h3;
    host_u.wr(8'h04, 8'h00);
    tick(3);
    host_u.rd(8'h04, d);
    check(d & 8'h38, 8'h18);
    @(posedge ref_clk) autoSensorControl <= 1'b0;
    $display("configuration done");
    // Each flag alone: higher enables must not see it, its own must
    for (int b = 0; b < 6; b++) begin
      pulse(6'(1 << b));
      host_u.wr(8'h03, 8'hFE << b);
      tick(3);
      check(hostIrq, 1'b0);
      host_u.wr(8'h03, 8'(1 << b));
      tick(3);
      check(hostIrq, 1'b1);
    end
    host_u.wr(8'h02, 8'h00);
    host_u.rd(8'h02, d);
    host_u.rd(8'h02, d);
    check(d, 8'h3F);
    // Gap mode: clear one of two pending flags
    host_u.clr(8'h3C);
    @(posedge ref_clk) intConfig <= 1'b1;
    host_u.wr(8'h03, 8'h03);
    host_u.clr(8'h01);
    tick(3);
    check(hostIrq, 1'b0);
    tick(480);
    check(hostIrq, 1'b0);
    tick(30);
    check(hostIrq, 1'b1);
    @(posedge ref_clk) intConfig <= 1'b0;
    pulse(6'h01);
    host_u.clr(8'h01);
    tick(3);
    check(hostIrq, 1'b1);
    // Event and clear in one cycle: the event must survive
    fork
      pulse(6'h01);
      host_u.clr(8'h01);
    join
    host_u.rd(8'h02, d);
    check(d, 8'h03);
    host_u.clr(8'h3F);
    host_u.rd(8'h02, d);
    check({d[6:0], hostIrq}, 8'h00);
    $display("interrupts done");
    // Independent sinks ignore the shared enable; PWM gates only enabled LEDs
    host_u.wr(8'h05, 8'h05);
    host_u.wr(8'h06, 8'h03);
    tick(3);
    check({1'b0, ledOn}, 8'h05);
    check({1'b0, ledPwmGate}, 8'h7C);
    @(posedge ref_clk) backlightOn <= 1'b1;
    @(posedge ref_clk) pwmIn <= 1'b1;
    tick(5);
    check({1'b0, ledOn}, 8'h7F);
    check({1'b0, ledPwmGate}, 8'h7F);
    @(posedge ref_clk) backlightOn <= 1'b0;
    $display("sinks done");
    // Dim after 2 s at full current, then off after 1 s
    host_u.wr(8'h08, 8'h02);
    host_u.wr(8'h07, 8'h01);
    @(posedge ref_clk) backlightOn <= 1'b1;
    tick(60);
    check(dimRequest, 1'b0);
    @(posedge ref_clk) atMaxCurrent <= 1'b1;
    countTo(1'b0);
    check(n >= 39 && n <= 42, 1'b1);
    countTo(1'b1);
    check(n >= 19 && n <= 22, 1'b1);
    tick(2);
    check({1'b0, ledOn}, 8'h05);
    @(posedge ref_clk) backlightOn <= 1'b0;
    host_u.wr(8'h08, 8'h00);
    host_u.wr(8'h07, 8'h7F);
    @(posedge ref_clk) backlightOn <= 1'b1;
    countTo(1'b1);
    check(n >= 2539 && n <= 2542, 1'b1);
    check(dimRequest, 1'b0);
    @(posedge ref_clk) backlightOn <= 1'b0;
    host_u.wr(8'h07, 8'h00);
    @(posedge ref_clk) backlightOn <= 1'b1;
    tick(300);
    check(offRequest, 1'b0);
    $display("timeouts done");
    // Second reset mid-run returns every register to zero
    @(posedge ref_clk) rst_n <= 1'b0;
    tick(2);
    @(posedge ref_clk) rst_n <= 1'b1;
    for (int a = 2; a < 9; a++) begin
      host_u.rd(8'(a), d);
      check(d, 8'h00);
    end
    check({ledSink6Enable, ledPwmGate}, 8'hFF);
    $display("reset done");
    end_sim();
  end
endmodule : backlight_ctrl_irq_regs_test
